// ===== src/irq_ctrl_consts.vh
`ifndef IRQ_CTRL_CONSTS_VH
`define IRQ_CTRL_CONSTS_VH

// ============================================================
// Register offsets on the plain register port.
`define OFS_WAKE_FLAGS    4'h0
`define OFS_WAKE_EDGE     4'h1
`define OFS_REQ_ONE       4'h2
`define OFS_ENABLE_ONE    4'h3
`define OFS_EXT_EDGE      4'h4
`define OFS_EVT_EDGE      4'h5
`define OFS_WAKE_FUNC     4'h6
`define OFS_PORT_FUNC     4'h7
`define OFS_REQ_TWO       4'h8
`define OFS_ENABLE_TWO    4'h9
`define OFS_STATUS        4'ha

// ============================================================
// Field positions.
`define BIT_EXT_A         0
`define BIT_EXT_B         1
`define BIT_EVT           2
`define BIT_WAKE_EN       5
`define BIT_CCR_MASK      7

// ============================================================
// Reset values.
`define RST_BYTE          8'h00
`define RST_PIN_IDLE      1'b1

// ============================================================
// Exception timing in states, one state per clock.
`define T_PUSH            3'd4
`define T_VEC_FETCH       3'd2
`define T_INSN_FETCH      3'd4
`define T_INTERNAL        3'd4
`define PUSH_CCR_SLOT     3'd2

// ============================================================
// Vector addresses.
`define RESET_VEC         16'h0000
`define IRQ_VEC_BASE      16'h0008

`endif

// ===== src/pin_edge_detect.v
`include "irq_ctrl_consts.vh"

module pin_edge_detect #(
  parameter W = 8
) (
  input  wire         mclk,
  input  wire         rst,
  input  wire [W-1:0] pin,
  input  wire [W-1:0] func,
  input  wire [W-1:0] rise_sel,
  input  wire [W-1:0] fall_sel,
  output reg  [W-1:0] edge_hit
);

  // ============================================================
  // Synchroniser and edge detection.
  reg  [W-1:0] sync_a;
  reg  [W-1:0] sync_b;
  reg  [W-1:0] prev;
  wire [W-1:0] gated;

  // A pin not in interrupt use reads idle high, so turning its function on while the pin
  // is low looks like a falling edge, as software is warned.
  assign gated = (sync_b & func) | ~func;

  // Two flops before any logic so one transition gives exactly one hit.
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      sync_a   <= {W{`RST_PIN_IDLE}};
      sync_b   <= {W{`RST_PIN_IDLE}};
      prev     <= {W{`RST_PIN_IDLE}};
      edge_hit <= {W{1'b0}};
    end
    else
    begin
      sync_a   <= pin;    // [RULE_22]
      sync_b   <= sync_a; // [RULE_22]
      prev     <= gated;
      edge_hit <= (rise_sel & ~prev & gated) | (fall_sel & prev & ~gated); // [RULE_22]
    end
  end

endmodule

// ===== src/request_flag_bank.v
`include "irq_ctrl_consts.vh"

module request_flag_bank #(
  parameter W = 8
) (
  input  wire         mclk,
  input  wire         rst,
  input  wire [W-1:0] set,
  input  wire         wr,
  input  wire [W-1:0] wdata,
  output reg  [W-1:0] flags
);

  // ============================================================
  // Sticky flags, cleared only by writing zero.
  wire [W-1:0] keep;
  wire [W-1:0] next_flags;

  // Writing one keeps a flag; a set in the clearing cycle wins so no event is lost.
  assign keep       = wr ? wdata : {W{1'b1}};    // [RULE_03]
  assign next_flags = (flags & keep) | set;      // [RULE_02] [RULE_20]

  // Acceptance never touches the flags; only software clears them.
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
      flags <= {W{1'b0}};
    else
      flags <= next_flags;
  end

endmodule

// ===== src/wakeup_irq_exception_ctrl.v
// Decided for this implementation: the plain strobed port and the register addresses.
`include "irq_ctrl_consts.vh"

// Operation
// [RULE_01] A wakeup flag sets when its pin is in wakeup use and its edge arrives.
// [RULE_02] Wakeup flags stay set on acceptance; software clears them by writing zero.
// [RULE_03] Writes to request flags only clear: zero clears, one leaves unchanged.
// [RULE_04] Per-pin wakeup edge bit resets to zero; zero falling, one rising.
// [RULE_05] Eight wakeup pins detect independently but share one vector.
// [RULE_06] One wakeup enable bit gates all eight wakeup requests together.
// [RULE_07] Two external request pins each own a vector and an edge bit.
// [RULE_08] External pin edge in interrupt use sets its flag; enable gates the request.
// [RULE_09] Event-counter pin edge, chosen by two bits, sets its flag when enabled.
// [RULE_10] Outside party holds reset at least ten clocks, longer at power-on.
// [RULE_11] After reset the mask bit is set and PC loads from vector zero.
// [RULE_12] Internal requests set flags and are forwarded only while enabled.
// [RULE_13] A request reaches the controller only while its enable bit is one.
// [RULE_14] Only the highest-priority pending request is presented; others wait.
// [RULE_15] Requests are accepted only while the mask bit is zero.
// [RULE_16] Acceptance follows instruction completion, then PC and CONDITION_CODE_REG are pushed.
// [RULE_17] After the push the mask sets; a CONDITION_CODE_REG reload restores every bit; this block restores only the mask bit, from bit 7.
// [RULE_18] The accepted source's vector is fetched and loaded into PC.
// [RULE_19] Software should clear enables or flags only while masked.
// [RULE_20] A clear colliding with a request still lets the exception follow.
// [RULE_21] Flag to handler takes 1-13 plus 4 push, 2, 4 and 4 states.
// [RULE_22] Pins are synchronised before edge detection so each edge counts once.
module wakeup_irq_exception_ctrl #(
  parameter NPER = 5
) (
  input  wire        mclk,
  input  wire        rst,
  input  wire [3:0]  addr,
  input  wire [7:0]  wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [7:0]  rdata,
  input  wire [7:0]  wake_pin,
  input  wire        ext_req_pin_a,
  input  wire        ext_req_pin_b,
  input  wire        event_counter_req_pin,
  input  wire [NPER-1:0] periph_event,
  input  wire        insn_done,
  input  wire [15:0] ret_pc,
  input  wire [7:0]  ccr_in,
  input  wire        ccr_load,
  input  wire [7:0]  ccr_load_data,
  input  wire [15:0] vec_data,
  output reg         i_mask,
  output reg         stack_we,
  output reg  [15:0] stack_data,
  output reg         vec_fetch,
  output reg  [15:0] vec_addr,
  output reg         pc_load,
  output reg  [15:0] pc_value,
  output reg         handler_start,
  output wire        busy
);

  // ============================================================
  // Source numbering, lowest index has highest priority.
  localparam NSRC = 4 + NPER;
  localparam [3:0] SRC_EXT_A = 4'h0;
  localparam [3:0] SRC_EXT_B = 4'h1;
  localparam [3:0] SRC_EVT   = 4'h2;
  localparam [3:0] SRC_WAKE  = 4'h3;

  // Sequencer states.
  localparam [2:0] S_RVEC   = 3'd0;
  localparam [2:0] S_IDLE   = 3'd1;
  localparam [2:0] S_PUSH   = 3'd2;
  localparam [2:0] S_VEC    = 3'd3;
  localparam [2:0] S_IFETCH = 3'd4;
  localparam [2:0] S_INT    = 3'd5;

  // ============================================================
  // Fixed priority pick over the gated requests.
  function [3:0] prio_pick;
    input [NSRC-1:0] req;
    integer k;
    begin
      prio_pick = 4'h0;
      for (k = NSRC - 1; k >= 0; k = k - 1)
        if (req[k])
          prio_pick = k[3:0];
    end
  endfunction

  // ============================================================
  // Software-visible control registers.
  reg  [7:0] wakeup_edge_select;
  reg  [7:0] enable_reg_one;
  reg  [7:0] ext_edge_select_reg;
  reg  [7:0] evt_edge_select_reg;
  reg  [7:0] wake_pin_func_reg;
  reg  [7:0] port_func_reg;
  reg  [7:0] enable_reg_two;

  wire wr_wake_flags = wr && (addr == `OFS_WAKE_FLAGS);
  wire wr_req_one    = wr && (addr == `OFS_REQ_ONE);
  wire wr_req_two    = wr && (addr == `OFS_REQ_TWO);

  // Plain read-write registers; the edge selects reset to zero meaning falling.
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      wakeup_edge_select  <= `RST_BYTE; // [RULE_04]
      enable_reg_one      <= `RST_BYTE;
      ext_edge_select_reg <= `RST_BYTE;
      evt_edge_select_reg <= `RST_BYTE;
      wake_pin_func_reg   <= `RST_BYTE;
      port_func_reg       <= `RST_BYTE;
      enable_reg_two      <= `RST_BYTE;
    end
    else if (wr)
    begin
      case (addr)
        `OFS_WAKE_EDGE:  wakeup_edge_select  <= wdata;
        `OFS_ENABLE_ONE: enable_reg_one      <= wdata;
        `OFS_EXT_EDGE:   ext_edge_select_reg <= {6'h00, wdata[1:0]};
        `OFS_EVT_EDGE:   evt_edge_select_reg <= {6'h00, wdata[1:0]};
        `OFS_WAKE_FUNC:  wake_pin_func_reg   <= wdata;
        `OFS_PORT_FUNC:  port_func_reg       <= {6'h00, wdata[1:0]};
        `OFS_ENABLE_TWO: enable_reg_two      <= wdata;
        default:         enable_reg_two      <= enable_reg_two;
      endcase
    end
  end

  // ============================================================
  // Edge detection on the wakeup and request pins.
  wire [7:0] wake_hit;
  wire [2:0] pin_hit;
  wire       wake_enable    = enable_reg_one[`BIT_WAKE_EN];
  wire       ext_enable_a   = enable_reg_one[`BIT_EXT_A];
  wire       ext_enable_b   = enable_reg_one[`BIT_EXT_B];
  wire       evt_pin_enable = enable_reg_one[`BIT_EVT];
  wire [1:0] evt_sel        = evt_edge_select_reg[1:0];
  wire       evt_rise       = evt_sel[1] | evt_sel[0];
  wire       evt_fall       = evt_sel[1] | ~evt_sel[0];
  wire [2:0] x_func;
  wire [2:0] x_rise;
  wire [2:0] x_fall;

  // Each wakeup pin has its own detector and edge bit.
  pin_edge_detect #(.W(8)) u_wake_edges (
    .mclk     (mclk),
    .rst      (rst),
    .pin      (wake_pin),
    .func     (wake_pin_func_reg),
    .rise_sel (wakeup_edge_select),      // [RULE_04] [RULE_05]
    .fall_sel (~wakeup_edge_select),     // [RULE_04]
    .edge_hit (wake_hit)
  );

  // The event pin has no function bit; its enable decides whether an edge counts.
  assign x_func = {1'b1, port_func_reg[1:0]};
  assign x_rise = {evt_rise, ext_edge_select_reg[1:0]};  // [RULE_07] [RULE_09]
  assign x_fall = {evt_fall, ~ext_edge_select_reg[1:0]}; // [RULE_07] [RULE_09]

  pin_edge_detect #(.W(3)) u_ext_edges (
    .mclk     (mclk),
    .rst      (rst),
    .pin      ({event_counter_req_pin, ext_req_pin_b, ext_req_pin_a}),
    .func     (x_func),
    .rise_sel (x_rise),
    .fall_sel (x_fall),
    .edge_hit (pin_hit)
  );

  // ============================================================
  // Sticky request flags.
  wire [7:0]      wakeup_request_flags;
  wire [2:0]      request_reg_one;
  wire [NPER-1:0] request_reg_two;
  wire [2:0]      set_one;

  // External pins set their flags regardless of enable; the event pin only when enabled.
  assign set_one = {pin_hit[2] & evt_pin_enable, pin_hit[1:0]}; // [RULE_08] [RULE_09]

  request_flag_bank #(.W(8)) u_wake_flags (
    .mclk  (mclk),
    .rst   (rst),
    .set   (wake_hit),                   // [RULE_01]
    .wr    (wr_wake_flags),              // [RULE_02] [RULE_03]
    .wdata (wdata),
    .flags (wakeup_request_flags)
  );

  request_flag_bank #(.W(3)) u_req_one (
    .mclk  (mclk),
    .rst   (rst),
    .set   (set_one),
    .wr    (wr_req_one),                 // [RULE_03]
    .wdata (wdata[2:0]),
    .flags (request_reg_one)
  );

  request_flag_bank #(.W(NPER)) u_req_two (
    .mclk  (mclk),
    .rst   (rst),
    .set   (periph_event),               // [RULE_12]
    .wr    (wr_req_two),                 // [RULE_03]
    .wdata (wdata[NPER-1:0]),
    .flags (request_reg_two)
  );

  // ============================================================
  // Enable gating and priority selection.
  wire [NSRC-1:0] gated_req;
  wire            req_any;
  wire [3:0]      req_src;

  // Flags stay visible when disabled, but only enabled ones reach the selector.
  assign gated_req = {request_reg_two & enable_reg_two[NPER-1:0],        // [RULE_12] [RULE_13]
                      wake_enable & (|wakeup_request_flags),             // [RULE_05] [RULE_06]
                      request_reg_one[`BIT_EVT] & evt_pin_enable,        // [RULE_13]
                      request_reg_one[`BIT_EXT_B] & ext_enable_b,        // [RULE_08]
                      request_reg_one[`BIT_EXT_A] & ext_enable_a};       // [RULE_08]
  assign req_any   = |gated_req;
  assign req_src   = prio_pick(gated_req);                               // [RULE_14]

  // ============================================================
  // Exception sequencer.
  reg  [2:0]  state;
  reg  [2:0]  next_state;
  reg  [2:0]  cnt;
  reg  [2:0]  next_cnt;
  reg  [3:0]  taken_src;
  reg  [7:0]  saved_ccr;
  wire        accept;
  wire        last;
  reg  [2:0]  span;

  // Acceptance waits for an instruction boundary and an open mask.
  assign accept = (state == S_IDLE) && insn_done && req_any && !i_mask; // [RULE_15] [RULE_16]
  assign busy   = (state != S_IDLE);

  // Length of the current step in states.
  always @*
  begin
    case (state)
      S_PUSH:   span = `T_PUSH;
      S_RVEC:   span = `T_VEC_FETCH;
      S_VEC:    span = `T_VEC_FETCH;
      S_IFETCH: span = `T_INSN_FETCH;
      S_INT:    span = `T_INTERNAL;
      default:  span = 3'd1;
    endcase
  end

  assign last = (cnt == span - 3'd1);

  // Step order: push, vector fetch, instruction fetch, internal, as fixed-length stages.
  always @*
  begin
    next_state = state;
    next_cnt   = cnt;
    case (state)
      S_IDLE:
      begin
        if (accept)
        begin
          next_state = S_PUSH;           // [RULE_16]
          next_cnt   = 3'd0;
        end
      end
      S_RVEC:
      begin
        next_cnt = last ? 3'd0 : cnt + 3'd1;
        if (last)
          next_state = S_IDLE;           // [RULE_11]
      end
      S_PUSH:
      begin
        next_cnt = last ? 3'd0 : cnt + 3'd1;
        if (last)
          next_state = S_VEC;            // [RULE_21]
      end
      S_VEC:
      begin
        next_cnt = last ? 3'd0 : cnt + 3'd1;
        if (last)
          next_state = S_IFETCH;         // [RULE_21]
      end
      S_IFETCH:
      begin
        next_cnt = last ? 3'd0 : cnt + 3'd1;
        if (last)
          next_state = S_INT;            // [RULE_21]
      end
      S_INT:
      begin
        next_cnt = last ? 3'd0 : cnt + 3'd1;
        if (last)
          next_state = S_IDLE;           // [RULE_21]
      end
      default:
      begin
        next_state = S_IDLE;
        next_cnt   = 3'd0;
      end
    endcase
  end

  // State, mask bit and captured source.
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state     <= S_RVEC;               // [RULE_11]
      cnt       <= 3'd0;
      i_mask    <= 1'b1;                 // [RULE_11]
      taken_src <= 4'h0;
      saved_ccr <= 8'h00;
    end
    else
    begin
      state <= next_state;
      cnt   <= next_cnt;
      if (accept)
      begin
        taken_src <= req_src;            // [RULE_14]
        saved_ccr <= {i_mask, ccr_in[6:0]};
      end
      // The mask closes once the push ends; a reload in idle restores only the mask bit, from bit 7.
      if (state == S_PUSH && last)
        i_mask <= 1'b1;                  // [RULE_17]
      else if (ccr_load && state == S_IDLE)
        i_mask <= ccr_load_data[`BIT_CCR_MASK]; // [RULE_17]
    end
  end

  // Bus-side strobes toward the core, all from flops.
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      stack_we      <= 1'b0;
      stack_data    <= 16'h0000;
      vec_fetch     <= 1'b0;
      vec_addr      <= `RESET_VEC;
      pc_load       <= 1'b0;
      pc_value      <= 16'h0000;
      handler_start <= 1'b0;
    end
    else
    begin
      stack_we      <= 1'b0;
      vec_fetch     <= 1'b0;
      pc_load       <= 1'b0;
      handler_start <= 1'b0;
      // Return address first, condition codes two states later.
      if (accept)
      begin
        stack_we   <= 1'b1;              // [RULE_16]
        stack_data <= ret_pc;
      end
      else if (state == S_PUSH && next_cnt == `PUSH_CCR_SLOT)
      begin
        stack_we   <= 1'b1;              // [RULE_16]
        stack_data <= {saved_ccr, saved_ccr};
      end
      // Fetch starts as the push ends; reset uses the fixed zero vector.
      if (state == S_PUSH && last)
      begin
        vec_fetch <= 1'b1;               // [RULE_18]
        vec_addr  <= `IRQ_VEC_BASE + {11'h000, taken_src, 1'b0}; // [RULE_05] [RULE_07]
      end
      else if (state == S_RVEC && cnt == 3'd0)
      begin
        vec_fetch <= 1'b1;               // [RULE_11]
        vec_addr  <= `RESET_VEC;
      end
      // Memory drives the vector word only while the fetch strobe stands, so take it then.
      if (vec_fetch)
      begin
        pc_load  <= 1'b1;                // [RULE_11] [RULE_18]
        pc_value <= vec_data;
      end
      if (state == S_INT && last)
        handler_start <= 1'b1;           // [RULE_21]
    end
  end

  // ============================================================
  // Register read port, data one cycle after the strobe.
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
      rdata <= 8'h00;
    else if (rd)
    begin
      case (addr)
        `OFS_WAKE_FLAGS: rdata <= wakeup_request_flags;
        `OFS_WAKE_EDGE:  rdata <= wakeup_edge_select;
        `OFS_REQ_ONE:    rdata <= {5'h00, request_reg_one};
        `OFS_ENABLE_ONE: rdata <= enable_reg_one;
        `OFS_EXT_EDGE:   rdata <= ext_edge_select_reg;
        `OFS_EVT_EDGE:   rdata <= evt_edge_select_reg;
        `OFS_WAKE_FUNC:  rdata <= wake_pin_func_reg;
        `OFS_PORT_FUNC:  rdata <= port_func_reg;
        `OFS_REQ_TWO:    rdata <= {{(8-NPER){1'b0}}, request_reg_two};
        `OFS_ENABLE_TWO: rdata <= enable_reg_two;
        `OFS_STATUS:     rdata <= {busy, i_mask, 3'b000, state};
        default:         rdata <= 8'h00;
      endcase
    end
    else
      rdata <= 8'h00;
  end

endmodule

// ===== verif/irq_ctrl_asserts.sv
// ============================================================
// Exception sequence checker, watching the controller's ports only.
module irq_ctrl_checker #(
  parameter NPER = 5
) (
  input wire        mclk,
  input wire        rst,
  input wire        insn_done,
  input wire [15:0] ret_pc,
  input wire        ccr_load,
  input wire [7:0]  ccr_load_data,
  input wire [15:0] vec_data,
  input wire        i_mask,
  input wire        stack_we,
  input wire [15:0] stack_data,
  input wire        vec_fetch,
  input wire [15:0] vec_addr,
  input wire        pc_load,
  input wire [15:0] pc_value,
  input wire        handler_start,
  input wire        busy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // Busy rises only one cycle after an accept, so it marks the accept edge.
  reset_vec_a: assert property ($past(rst) && !rst |=>
    vec_fetch && vec_addr == 16'h0000 && i_mask)
    else $error("Reset vector fetch missing.");
  accept_cond_a: assert property ($rose(busy) |->
    $past(insn_done) && !$past(i_mask))
    else $error("Accept without boundary or with mask set.");
  push_order_a: assert property ($rose(busy) |->
    stack_we && stack_data == $past(ret_pc) ##1 !stack_we
    ##1 stack_we && stack_data[15:8] == stack_data[7:0] && !stack_data[7])
    else $error("Stack push order or data wrong.");
  mask_set_a: assert property ($rose(busy) |->
    !i_mask [*4] ##1 (i_mask && vec_fetch))
    else $error("Mask not set after the push.");
  vec_range_a: assert property (vec_fetch && $past(stack_we, 2) |->
    !vec_addr[0] && vec_addr >= 16'h0008 && vec_addr < 16'h0008 + 2 * (4 + NPER))
    else $error("Vector address outside the table.");
  vec_to_pc_a: assert property (vec_fetch |=>
    pc_load && pc_value == $past(vec_data))
    else $error("PC not loaded from the vector word.");
  latency_a: assert property ($rose(busy) |->
    ##13 (busy && !handler_start) ##1 (handler_start && !busy))
    else $error("Handler start latency wrong.");
  mask_clear_a: assert property ($fell(i_mask) |->
    $past(ccr_load) && !$past(busy) && !$past(ccr_load_data[7]))
    else $error("Mask cleared without a reload.");
endmodule

bind wakeup_irq_exception_ctrl irq_ctrl_checker #(.NPER(NPER)) u_chk (
  .mclk(mclk), .rst(rst), .insn_done(insn_done), .ret_pc(ret_pc),
  .ccr_load(ccr_load), .ccr_load_data(ccr_load_data), .vec_data(vec_data),
  .i_mask(i_mask), .stack_we(stack_we), .stack_data(stack_data),
  .vec_fetch(vec_fetch), .vec_addr(vec_addr), .pc_load(pc_load),
  .pc_value(pc_value), .handler_start(handler_start), .busy(busy)
);

// ===== verif/cpu_core_model.sv
// ============================================================
// Processor core model: instruction boundaries, returns, vector memory.
module cpu_core_model (
  input  wire         mclk,
  input  wire         rst,
  input  wire         vec_fetch,
  input  wire  [15:0] vec_addr,
  input  wire         ret_go,
  input  wire  [7:0]  ret_val,
  output logic        insn_done,
  output logic [15:0] ret_pc,
  output wire  [7:0]  ccr_in,
  output logic        ccr_load,
  output logic [7:0]  ccr_load_data,
  output wire  [15:0] vec_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] left;
  int         len;

  // Instruction lengths step through 1 to 13 states so acceptance waits vary.
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      left <= 4'h0;
      len <= 0;
      insn_done <= 1'b0;
      ret_pc <= 16'h1000;
      ccr_load <= 1'b0;
      ccr_load_data <= 8'h80;
    end
    else
    begin
      insn_done <= (left == 4'h0);
      len <= (len + 5) % 13;
      left <= (left == 4'h0) ? len[3:0] : left - 4'h1;
      ret_pc <= insn_done ? ret_pc + 16'h0002 : ret_pc;
      ccr_load <= ret_go;
      ccr_load_data <= ret_val;
    end
  end

  // Memory answers only while fetched; otherwise the bus shows the inverse.
  assign ccr_in = ret_pc[8:1];
  assign vec_data = vec_fetch ? (vec_addr ^ 16'h5a00) : ~(vec_addr ^ 16'h5a00);
endmodule

// ===== verif/testbench.sv
`include "irq_ctrl_consts.vh"

// ============================================================
// Self-checking bench for the interrupt and exception controller.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam NPER = 5;
  logic            mclk = 1'b0;
  logic            rst = 1'b1;
  logic [3:0]      addr = 4'h0;
  logic [7:0]      wdata = 8'h00;
  logic            wr = 1'b0;
  logic            rd = 1'b0;
  logic [7:0]      wake_pin = 8'hff;
  logic            ext_a = 1'b1;
  logic            ext_b = 1'b1;
  logic            evt_pin = 1'b1;
  logic [NPER-1:0] periph_event = 5'h00;
  logic            ret_go = 1'b0;
  logic [7:0]      ret_val = 8'h80;
  wire  [7:0]      rdata, ccr_in, ccr_load_data;
  wire             insn_done, ccr_load, i_mask, stack_we, vec_fetch, pc_load, handler_start, busy;
  wire  [15:0]     ret_pc, stack_data, vec_addr, pc_value, vec_data;
  integer          fails = 0, n_compared = 0, cyc = 0, n_fetch = 0;
  integer          seed = 52677, i, k, nf;
  logic [7:0]      wf = 8'h00, r1 = 8'h00, sel, np, m;

  wakeup_irq_exception_ctrl #(.NPER(NPER)) u_dut (
    .mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .wake_pin(wake_pin), .ext_req_pin_a(ext_a), .ext_req_pin_b(ext_b),
    .event_counter_req_pin(evt_pin), .periph_event(periph_event),
    .insn_done(insn_done), .ret_pc(ret_pc), .ccr_in(ccr_in), .ccr_load(ccr_load),
    .ccr_load_data(ccr_load_data), .vec_data(vec_data), .i_mask(i_mask),
    .stack_we(stack_we), .stack_data(stack_data), .vec_fetch(vec_fetch),
    .vec_addr(vec_addr), .pc_load(pc_load), .pc_value(pc_value),
    .handler_start(handler_start), .busy(busy)
  );
  cpu_core_model u_cpu (
    .mclk(mclk), .rst(rst), .vec_fetch(vec_fetch), .vec_addr(vec_addr),
    .ret_go(ret_go), .ret_val(ret_val), .insn_done(insn_done), .ret_pc(ret_pc),
    .ccr_in(ccr_in), .ccr_load(ccr_load), .ccr_load_data(ccr_load_data),
    .vec_data(vec_data)
  );

  always #12.5 mclk = ~mclk;

  // Counts vector fetches and cuts a hung run short.
  always @(posedge mclk)
  begin
    cyc = cyc + 1;
    if (vec_fetch === 1'b1)
      n_fetch = n_fetch + 1;
    if (cyc == 12000)
    begin
      fails = fails + 1;
      stop_test;
    end
  end

  // ============================================================
  // Shared tasks.
  function automatic logic [7:0] hits(input logic [7:0] o, n, r);
    return (~o & n & r) | (o & ~n & ~r);
  endfunction

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
  begin
    n_compared = n_compared + 1;
    if (seen !== exp)
    begin
      fails = fails + 1;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
  begin
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  end
  endtask

  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp, input string what);
  begin
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    chk(what, {8'h00, rdata}, {8'h00, exp});
  end
  endtask

  task automatic ret_to(input logic [7:0] v);
  begin
    @(posedge mclk);
    ret_go <= 1'b1;
    ret_val <= v;
    @(posedge mclk);
    ret_go <= 1'b0;
  end
  endtask

  task automatic expect_handler(input logic [15:0] va);
  begin
    k = 0;
    while (vec_fetch !== 1'b1 && k < 80)
    begin
      @(negedge mclk);
      k = k + 1;
    end
    chk("vec_addr", vec_addr, va);
    @(negedge mclk);
    chk("pc_value", pc_value, va ^ 16'h5a00);
    repeat (9) @(negedge mclk);
    chk("handler_start", {15'h0000, handler_start}, 16'h0001);
  end
  endtask

  task automatic stop_test;
  begin
    $display("Compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask

  // ============================================================
  // Main sequence.
  initial
  begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(negedge mclk);
    chk("reset pc", pc_value, 16'h5a00);
    chk("i_mask", {15'h0000, i_mask}, 16'h0001);
    rd_reg(`OFS_WAKE_EDGE, 8'h00, "wake edge");
    rd_reg(4'hf, 8'h00, "unmapped");
    wr_reg(`OFS_WAKE_FUNC, 8'hff);
    // Random pin patterns against random edge selects, with random clears.
    for (i = 0; i < 16; i = i + 1)
    begin
      sel = $random(seed);
      np = $random(seed);
      m = $random(seed);
      wr_reg(`OFS_WAKE_EDGE, sel);
      @(posedge mclk);
      wf = wf | hits(wake_pin, np, sel);
      wake_pin <= np;
      repeat (4) @(posedge mclk);
      rd_reg(`OFS_WAKE_FLAGS, wf, "wake flags");
      wr_reg(`OFS_WAKE_FLAGS, m);
      wf = wf & m;
      rd_reg(`OFS_WAKE_FLAGS, wf, "wake flags");
    end
    rd_reg(`OFS_WAKE_EDGE, sel, "wake edge");
    wr_reg(`OFS_PORT_FUNC, 8'h03);
    // Every external edge select and event code, event pin enabled only at first.
    for (i = 0; i < 8; i = i + 1)
    begin
      np = $random(seed);
      wr_reg(`OFS_EXT_EDGE, {6'h00, i[1:0]});
      wr_reg(`OFS_EVT_EDGE, {6'h00, i[1:0]});
      wr_reg(`OFS_ENABLE_ONE, {5'h00, i < 4, 2'b00});
      @(posedge mclk);
      r1 = hits({6'h00, ext_b, ext_a}, np, {6'h00, i[1:0]});
      if (i < 4 && evt_pin !== np[2] && (i[1] || np[2] == i[0]))
        r1[2] = 1'b1;
      ext_a <= np[0];
      ext_b <= np[1];
      evt_pin <= np[2];
      repeat (4) @(posedge mclk);
      rd_reg(`OFS_REQ_ONE, r1, "request one");
      wr_reg(`OFS_REQ_ONE, 8'h00);
    end
    wr_reg(`OFS_ENABLE_TWO, 8'h01);
    @(posedge mclk);
    periph_event <= 5'h06;
    @(posedge mclk);
    periph_event <= 5'h00;
    rd_reg(`OFS_REQ_TWO, 8'h06, "request two");
    wr_reg(`OFS_REQ_TWO, 8'h00);
    // Two sources pending at once: the external pin wins, the wakeup waits.
    wr_reg(`OFS_WAKE_FLAGS, 8'h00);
    wr_reg(`OFS_EXT_EDGE, 8'h00);
    wr_reg(`OFS_WAKE_EDGE, 8'h00);
    @(posedge mclk);
    wake_pin <= 8'hff;
    ext_a <= 1'b1;
    repeat (4) @(posedge mclk);
    wake_pin <= 8'hf7;
    ext_a <= 1'b0;
    repeat (4) @(posedge mclk);
    wr_reg(`OFS_ENABLE_ONE, 8'h21);
    ret_to(8'h00);
    expect_handler(16'h0008);
    rd_reg(`OFS_REQ_ONE, 8'h01, "request one");
    wr_reg(`OFS_REQ_ONE, 8'h00);
    ret_to(8'h00);
    expect_handler(16'h000e);
    rd_reg(`OFS_WAKE_FLAGS, 8'h08, "wake flags");
    nf = n_fetch;
    repeat (30) @(posedge mclk);
    chk("masked fetches", n_fetch[15:0], nf[15:0]);
    wr_reg(`OFS_ENABLE_ONE, 8'h00);
    ret_to(8'h00);
    repeat (30) @(posedge mclk);
    chk("gated fetches", n_fetch[15:0], nf[15:0]);
    wr_reg(`OFS_ENABLE_ONE, 8'h20);
    expect_handler(16'h000e);
    wr_reg(`OFS_ENABLE_ONE, 8'h00);
    wr_reg(`OFS_WAKE_FLAGS, 8'h00);
    @(posedge mclk);
    periph_event <= 5'h01;
    wr_reg(`OFS_REQ_TWO, 8'h00);
    periph_event <= 5'h00;
    ret_to(8'h00);
    expect_handler(16'h0010);
    stop_test;
  end
endmodule
